// ==== logic/adc_cfg_pkg.sv ====
// Constants, field layouts and carriers for the ADC channel config registers.
// Assumes 8-bit registers at 13-bit addresses on a three-wire serial port.
package adc_cfg_pkg;

  // ********************************************************
  // Register addresses
  // ********************************************************
  localparam logic [12:0] ADDR_UPPER_SEL = 13'h0004;
  localparam logic [12:0] ADDR_LOWER_SEL = 13'h0005;
  localparam logic [12:0] ADDR_MODES     = 13'h0008;
  localparam logic [12:0] ADDR_CLOCK     = 13'h0009;
  localparam logic [12:0] ADDR_TEST      = 13'h000D;
  localparam logic [12:0] ADDR_TRANSFER  = 13'h00FF;

  // ********************************************************
  // Reset values and writable-bit masks
  // ********************************************************
  localparam logic [7:0] RST_UPPER_SEL  = 8'h0F;
  localparam logic [7:0] RST_LOWER_SEL  = 8'h0F;
  localparam logic [7:0] RST_MODES      = 8'h00;
  localparam logic [7:0] RST_CLOCK      = 8'h01;
  localparam logic [7:0] RST_TEST       = 8'h00;
  localparam logic [7:0] RST_TRANSFER   = 8'h00;
  localparam logic [7:0] MASK_UPPER_SEL = 8'h0F;
  localparam logic [7:0] MASK_LOWER_SEL = 8'h3F;
  localparam logic [7:0] MASK_MODES     = 8'h0F;
  localparam logic [7:0] MASK_CLOCK     = 8'h01;

  // ********************************************************
  // Field positions and codes
  // ********************************************************
  localparam int TRANSFER_BIT   = 0;
  localparam int DCS_BIT        = 0;
  localparam int PREAMP_BYP_BIT = 3;
  localparam int FRAME_CLK_BIT  = 4;
  localparam int DATA_CLK_BIT   = 5;
  localparam logic [2:0] PWR_NORMAL  = 3'h0;
  localparam logic [2:0] PWR_DOWN    = 3'h1;
  localparam logic [2:0] PWR_STANDBY = 3'h2;
  localparam logic [2:0] PWR_RESET   = 3'h3;

  localparam logic [3:0] TP_OFF        = 4'h0;
  localparam logic [3:0] TP_MIDSCALE   = 4'h1;
  localparam logic [3:0] TP_POS_FS     = 4'h2;
  localparam logic [3:0] TP_NEG_FS     = 4'h3;
  localparam logic [3:0] TP_CHECKER    = 4'h4;
  localparam logic [3:0] TP_PRS_LONG   = 4'h5;
  localparam logic [3:0] TP_PRS_SHORT  = 4'h6;
  localparam logic [3:0] TP_WORD_TOG   = 4'h7;
  localparam logic [3:0] TP_USER       = 4'h8;
  localparam logic [3:0] TP_BIT_TOG    = 4'h9;
  localparam logic [3:0] TP_SYNC       = 4'hA;
  localparam logic [3:0] TP_ONE_BIT    = 4'hB;
  localparam logic [3:0] TP_MIXED_FREQ = 4'hC;

  localparam logic [1:0] USER_OFF      = 2'h0;
  localparam logic [1:0] USER_ALT_CONT = 2'h1;
  localparam logic [1:0] USER_ONCE     = 2'h2;
  localparam logic [1:0] USER_ALT_ONCE = 2'h3;

  // ********************************************************
  // Serial framing and generator constants
  // ********************************************************
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [3:0] DATA_LAST_BIT  = 4'h7;
  localparam logic [8:0]  PRS_SHORT_SEED = 9'h1FF;
  localparam logic [22:0] PRS_LONG_SEED  = 23'h7FFFFF;

  typedef enum logic {ST_INSTR, ST_DATA} serial_state_type;

  // Test register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] user_seq;
    logic       prs_long_rst;
    logic       prs_short_rst;
    logic [3:0] pattern;
  } test_ctrl_type;

  // One register write leaving the serial engine
  typedef struct packed {
    logic        en;
    logic [12:0] addr;
    logic [7:0]  data;
  } reg_write_type;

endpackage

// ==== logic/adc_channel_config_regs.sv ====
// Serial-port register bank: channel selection, latch transfer, modes,
// clock and test pattern generation for an eight-channel receive ADC.
// Assumes serial pins are asynchronous and much slower than clk_sys.
`timescale 1ns/1ps
module adc_channel_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int DW     = 12
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Serial port pins
  input  wire logic                     sclk,
  input  wire logic                     csb,
  input  wire logic                     sdio_i,
  output logic                          sdio_o,
  output logic                          sdio_oe,
  // Conversion data path
  input  wire logic                     sample_tick,
  input  wire logic [NUM_CH-1:0][DW-1:0] adc_data,
  input  wire logic [DW-1:0]            user_word1,
  input  wire logic [DW-1:0]            user_word2,
  output logic      [NUM_CH-1:0][DW-1:0] out_data,
  output logic      [NUM_CH-1:0]        test_active,
  // Analog and clock controls
  output logic                          power_down,
  output logic                          standby,
  output logic                          chip_reset,
  output logic                          preamp_bypass,
  output logic                          dcs_enable,
  output logic                          frame_clock_output_sel,
  output logic                          data_clock_output_sel
);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [2:0] sclk_sync_q;
  logic [1:0] csb_sync_q;
  logic [1:0] sdio_sync_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_sync_q <= 3'h0;
      csb_sync_q  <= 2'h3;
      sdio_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      csb_sync_q  <= {csb_sync_q[0], csb};
      sdio_sync_q <= {sdio_sync_q[0], sdio_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic csb_s;
  logic sdio_s;
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign csb_s     = csb_sync_q[1];
  assign sdio_s    = sdio_sync_q[1];

  // ********************************************************
  // Register state
  // ********************************************************
  logic [7:0]                    upper_master_q, upper_master_d;
  logic [7:0]                    lower_master_q, lower_master_d;
  logic [7:0]                    upper_slave_q, upper_slave_d;
  logic [7:0]                    lower_slave_q, lower_slave_d;
  logic [7:0]                    modes_q, modes_d;
  logic [7:0]                    clock_q, clock_d;
  test_ctrl_type [NUM_CH-1:0]    test_q, test_d;
  logic [NUM_CH-1:0]             ch_sel;
  reg_write_type                 wr;

  assign ch_sel = NUM_CH'({upper_slave_q[3:0], lower_slave_q[3:0]});

  // Multiple channels selected: reads show the lowest one
  function automatic logic [7:0] read_reg(input logic [12:0] addr);
    logic [7:0] rd;
    rd = 8'h00;
    unique case (addr)
      ADDR_UPPER_SEL: rd = upper_master_q;
      ADDR_LOWER_SEL: rd = lower_master_q;
      ADDR_MODES:     rd = modes_q;
      ADDR_CLOCK:     rd = clock_q;
      ADDR_TEST: begin
        for (int c = NUM_CH - 1; c >= 0; c--) begin
          if (ch_sel[c]) begin
            rd = test_q[c];
          end
        end
      end
      default:        rd = 8'h00;
    endcase
    return rd;
  endfunction

  // ********************************************************
  // Serial engine
  // ********************************************************
  serial_state_type ser_state_q, ser_state_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [15:0]      shift_q, shift_d;
  logic [12:0]      addr_q, addr_d;
  logic             rd_q, rd_d;
  logic [7:0]       tx_q, tx_d;
  logic             fresh_q, fresh_d;

  always_comb begin
    ser_state_d = ser_state_q;
    cnt_d       = cnt_q;
    shift_d     = shift_q;
    addr_d      = addr_q;
    rd_d        = rd_q;
    tx_d        = tx_q;
    fresh_d     = fresh_q;
    wr          = '0;
    if (csb_s) begin
      ser_state_d = ST_INSTR;
      cnt_d       = 4'h0;
      rd_d        = 1'b0;
    end else if (sclk_rise) begin
      shift_d = {shift_q[14:0], sdio_s};
      cnt_d   = cnt_q + 4'h1;
      if (ser_state_q == ST_INSTR && cnt_q == INSTR_LAST_BIT) begin
        // Length bits ignored: streaming runs until chip select rises
        ser_state_d = ST_DATA;
        cnt_d       = 4'h0;
        rd_d        = shift_d[15];
        addr_d      = shift_d[12:0];
        fresh_d     = 1'b1;
      end else if (ser_state_q == ST_DATA && cnt_q == DATA_LAST_BIT) begin
        cnt_d   = 4'h0;
        addr_d  = addr_q - 13'h0001;
        wr.en   = ~rd_q;
        wr.addr = addr_q;
        wr.data = shift_d[7:0];
        fresh_d = 1'b1;
      end
    end else if (sclk_fall && ser_state_q == ST_DATA && rd_q) begin
      // Load on a fall, so a byte's last bit still stands at its rise
      if (fresh_q) begin
        tx_d    = read_reg(addr_q);
        fresh_d = 1'b0;
      end else begin
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ser_state_q <= ST_INSTR;
      cnt_q       <= 4'h0;
      shift_q     <= 16'h0000;
      addr_q      <= 13'h0000;
      rd_q        <= 1'b0;
      tx_q        <= 8'h00;
      fresh_q     <= 1'b0;
    end else begin
      ser_state_q <= ser_state_d;
      cnt_q       <= cnt_d;
      shift_q     <= shift_d;
      addr_q      <= addr_d;
      rd_q        <= rd_d;
      tx_q        <= tx_d;
      fresh_q     <= fresh_d;
    end
  end

  assign sdio_o  = tx_q[7];
  assign sdio_oe = (ser_state_q == ST_DATA) & rd_q & ~csb_s;

  // ********************************************************
  // Register writes
  // ********************************************************
  test_ctrl_type wr_test;
  logic          wr_prs;
  assign wr_test = test_ctrl_type'(wr.data);
  assign wr_prs  = (wr_test.pattern == TP_PRS_LONG) |
                   (wr_test.pattern == TP_PRS_SHORT);

  always_comb begin
    upper_master_d = upper_master_q;
    lower_master_d = lower_master_q;
    upper_slave_d  = upper_slave_q;
    lower_slave_d  = lower_slave_q;
    modes_d        = modes_q;
    clock_d        = clock_q;
    test_d         = test_q;
    if (wr.en) begin
      unique case (wr.addr)
        ADDR_UPPER_SEL: upper_master_d = wr.data & MASK_UPPER_SEL;
        ADDR_LOWER_SEL: lower_master_d = wr.data & MASK_LOWER_SEL;
        ADDR_TRANSFER: begin
          // Transfer bit is a strobe, so it reads back as zero
          if (wr.data[TRANSFER_BIT]) begin
            upper_slave_d = upper_master_q;
            lower_slave_d = lower_master_q;
          end
        end
        ADDR_MODES:     modes_d = wr.data & MASK_MODES;
        ADDR_CLOCK:     clock_d = wr.data & MASK_CLOCK;
        ADDR_TEST: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (ch_sel[c] || wr_prs) begin
              test_d[c] = wr_test;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      upper_master_q <= RST_UPPER_SEL;
      lower_master_q <= RST_LOWER_SEL;
      upper_slave_q  <= RST_UPPER_SEL;
      lower_slave_q  <= RST_LOWER_SEL;
      modes_q        <= RST_MODES;
      clock_q        <= RST_CLOCK;
      test_q         <= {NUM_CH{test_ctrl_type'(RST_TEST)}};
    end else begin
      upper_master_q <= upper_master_d;
      lower_master_q <= lower_master_d;
      upper_slave_q  <= upper_slave_d;
      lower_slave_q  <= lower_slave_d;
      modes_q        <= modes_d;
      clock_q        <= clock_d;
      test_q         <= test_d;
    end
  end

  assign power_down    = modes_q[2:0] == PWR_DOWN;
  assign standby       = modes_q[2:0] == PWR_STANDBY;
  assign chip_reset    = modes_q[2:0] == PWR_RESET;
  assign preamp_bypass = modes_q[PREAMP_BYP_BIT];
  assign dcs_enable    = clock_q[DCS_BIT];
  assign frame_clock_output_sel = lower_slave_q[FRAME_CLK_BIT];
  assign data_clock_output_sel  = lower_slave_q[DATA_CLK_BIT];

  // ********************************************************
  // Shared pattern generators
  // ********************************************************
  // Generators are global, so resets take effect if any channel asks
  logic [8:0]  prs_short_q, prs_short_d;
  logic [22:0] prs_long_q, prs_long_d;
  logic        phase_q, phase_d;
  logic [1:0]  user_cnt_q, user_cnt_d;
  logic        any_short_rst;
  logic        any_long_rst;

  always_comb begin
    any_short_rst = 1'b0;
    any_long_rst  = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      any_short_rst = any_short_rst | test_q[c].prs_short_rst;
      any_long_rst  = any_long_rst | test_q[c].prs_long_rst;
    end
    prs_short_d = prs_short_q;
    prs_long_d  = prs_long_q;
    phase_d     = phase_q;
    user_cnt_d  = user_cnt_q;
    if (sample_tick) begin
      prs_short_d = {prs_short_q[7:0], prs_short_q[8] ^ prs_short_q[4]};
      prs_long_d  = {prs_long_q[21:0], prs_long_q[22] ^ prs_long_q[17]};
      phase_d     = ~phase_q;
      if (user_cnt_q != 2'h2) begin
        user_cnt_d = user_cnt_q + 2'h1;
      end
    end
    if (any_short_rst) begin
      prs_short_d = PRS_SHORT_SEED;
    end
    if (any_long_rst) begin
      prs_long_d = PRS_LONG_SEED;
    end
    // A test write restarts the once-only user sequences
    if (wr.en && wr.addr == ADDR_TEST) begin
      user_cnt_d = 2'h0;
      phase_d    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prs_short_q <= PRS_SHORT_SEED;
      prs_long_q  <= PRS_LONG_SEED;
      phase_q    <= 1'b0;
      user_cnt_q <= 2'h0;
    end else begin
      prs_short_q <= prs_short_d;
      prs_long_q  <= prs_long_d;
      phase_q    <= phase_d;
      user_cnt_q <= user_cnt_d;
    end
  end

  // Once-only modes fall back to zero word after their last sample
  function automatic logic [DW-1:0] user_word(input logic [1:0] seq);
    logic [DW-1:0] w;
    w = phase_q ? user_word2 : user_word1;
    unique case (seq)
      USER_ONCE:     w = (user_cnt_q == 2'h0) ? user_word1 : '0;
      USER_ALT_ONCE: w = (user_cnt_q != 2'h2) ? w : '0;
      default:       w = w;
    endcase
    return w;
  endfunction

  function automatic logic [DW-1:0] pattern_word(input test_ctrl_type t);
    logic [DW-1:0] w;
    w = '0;
    unique case (t.pattern)
      TP_MIDSCALE:   w = {1'b1, {(DW-1){1'b0}}};
      TP_POS_FS:     w = '1;
      TP_NEG_FS:     w = '0;
      TP_CHECKER:    w = phase_q ? {(DW/2){2'b01}} : {(DW/2){2'b10}};
      TP_PRS_LONG:   w = prs_long_q[DW-1:0];
      TP_PRS_SHORT:  w = {3'h0, prs_short_q};
      TP_WORD_TOG:   w = phase_q ? '0 : '1;
      TP_USER:       w = user_word(t.user_seq);
      TP_BIT_TOG:    w = {(DW/2){2'b10}};
      TP_SYNC:       w = {{(DW/2){1'b0}}, {(DW/2){1'b1}}};
      TP_ONE_BIT:    w = {1'b1, {(DW-1){1'b0}}};
      TP_MIXED_FREQ: w = {(DW/4){4'hA}} ^ {{(DW/2){1'b0}}, {(DW/2){1'b1}}};
      default:       w = '0;
    endcase
    return w;
  endfunction

  // ********************************************************
  // Per-channel output selection
  // ********************************************************
  logic [NUM_CH-1:0][DW-1:0] out_data_q, out_data_d;
  logic [NUM_CH-1:0]         active_q, active_d;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_comb begin
      active_d[g]   = test_q[g].pattern != TP_OFF;
      out_data_d[g] = active_d[g] ? pattern_word(test_q[g])
                                  : adc_data[g];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_data_q <= '0;
      active_q   <= '0;
    end else begin
      out_data_q <= out_data_d;
      active_q   <= active_d;
    end
  end

  assign out_data    = out_data_q;
  assign test_active = active_q;

endmodule

// ==== test/adc_channel_config_regs_monitor.sv ====
// Port assertions for the ADC channel config register bank.
// Assumes it is bound into adc_channel_config_regs with its parameters.
`timescale 1ns/1ps
module adc_cfg_monitor #(
  parameter int NUM_CH = 8,
  parameter int DW     = 12
) (
  // Clock, reset and serial pins
  input wire logic                      clk_sys,
  input wire logic                      rst,
  input wire logic                      csb,
  // Data path and controls
  input wire logic [NUM_CH-1:0][DW-1:0] adc_data,
  input wire logic [NUM_CH-1:0][DW-1:0] out_data,
  input wire logic [NUM_CH-1:0]         test_active,
  input wire logic                      power_down,
  input wire logic                      standby,
  input wire logic                      chip_reset,
  input wire logic                      preamp_bypass,
  input wire logic                      dcs_enable,
  input wire logic                      frame_clock_output_sel,
  input wire logic                      data_clock_output_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ********
  // Checks
  // ********
  chk_reset_regs: assert property (
    disable iff (1'b0) rst |=> dcs_enable && !preamp_bypass)
    else $error("control outputs wrong after reset");
  chk_reset_sel: assert property (
    disable iff (1'b0)
      rst |=> !frame_clock_output_sel && !data_clock_output_sel)
    else $error("clock output selects set after reset");
  chk_reset_test: assert property (
    disable iff (1'b0) rst |=> test_active == '0 && out_data == '0)
    else $error("test outputs wrong after reset");
  chk_power_onehot: assert property (
    $onehot0({power_down, standby, chip_reset}))
    else $error("two power modes at once");
  chk_pass_thru: assert property (
    !test_active[0] && !$past(rst) |-> out_data[0] == $past(adc_data[0]))
    else $error("channel 0 lost conversion data");
  // A write lands three cycles after its last serial rise (test_active one later), inside the frame
  chk_sel_in_frame: assert property (
    $changed({frame_clock_output_sel, data_clock_output_sel}) |-> !$past(csb, 4))
    else $error("clock select moved outside a frame");
  chk_modes_in_frame: assert property (
    $changed({power_down, standby, chip_reset, preamp_bypass})
      |-> !$past(csb, 4))
    else $error("mode output moved outside a frame");
  chk_dcs_in_frame: assert property (
    $changed(dcs_enable) |-> !$past(csb, 4))
    else $error("stabilizer control moved outside a frame");
  chk_test_in_frame: assert property (
    $changed(test_active) |-> !$past(csb, 4))
    else $error("test activity moved outside a frame");
  cover property (chip_reset);
  cover property (test_active == '1);
  cover property ($rose(frame_clock_output_sel));
endmodule

// ==== test/serial_host_model.sv ====
// Serial-port host model framing register reads and writes.
// Assumes clk_sys at 25 ns; each serial bit lasts 8 cycles, 200 ns.
`timescale 1ns/1ps
module serial_host_model (
  // Clock and serial pins
  input  wire logic       clk_sys,
  output logic            sclk = 1'b0,
  output logic            csb = 1'b1,
  output logic            sdio_i,
  input  wire logic       sdio_o,
  input  wire logic       sdio_oe,
  // Read results
  output logic            rd_valid = 1'b0,
  output logic [7:0]      rd_data = 8'h00
);
  logic drv_q = 1'b0;
  // Released line toggles so stale data never passes for a read
  assign sdio_i = sdio_oe ? sdio_o : drv_q;

  task automatic xfer(input logic rd, input logic [12:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] word;
    word = {rd, 2'b00, addr, wdata};
    rdata = 8'h00;
    @(posedge clk_sys) csb <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 23; i >= 0; i--) begin
      sclk <= 1'b0;
      drv_q <= (rd && i < 8) ? ~drv_q : word[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // Late in the high phase, well clear of the shift on the fall
      if (rd && i < 8) rdata[i] = sdio_i;
    end
    sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    csb <= 1'b1;
    repeat (8) @(posedge clk_sys);
    if (rd) begin
      rd_data <= rdata;
      rd_valid <= 1'b1;
      @(posedge clk_sys) rd_valid <= 1'b0;
    end
  endtask
endmodule

// ==== test/adc_channel_config_regs_test.sv ====
// Self-checking bench for the ADC channel config register bank.
// Assumes the serial host model and the port monitor beside the design.
`timescale 1ns/1ps
module adc_channel_config_regs_test;
  import adc_cfg_pkg::*;
  localparam int NUM_CH = 8;
  localparam int DW     = 12;
  logic                      clk_sys = 1'b0;
  logic                      rst = 1'b1;
  logic                      sample_tick = 1'b0;
  logic [NUM_CH-1:0][DW-1:0] adc_data = '0;
  logic [NUM_CH-1:0][DW-1:0] prev_adc = '0;
  logic [DW-1:0]             user_word1 = '0;
  logic [DW-1:0]             user_word2 = '0;
  logic [DW-1:0]             a;
  logic [DW-1:0]             b;
  logic [15:0]               lfsr_q = 16'h0049;
  logic [7:0]                exp_q[$];
  logic                      prs_all = 1'b0;
  int                        failures = 0;
  int                        num_checks = 0;
  wire                       sclk, csb, sdio_i, sdio_o, sdio_oe, rd_valid;
  wire  [7:0]                rd_data;
  wire  [NUM_CH-1:0][DW-1:0] out_data;
  wire  [NUM_CH-1:0]         test_active;
  wire                       power_down, standby, chip_reset;
  wire                       preamp_bypass, dcs_enable, frame_sel, data_sel;
  logic [12:0] addr_t [7] = '{ADDR_UPPER_SEL, ADDR_LOWER_SEL, ADDR_MODES,
                              ADDR_CLOCK, ADDR_TEST, ADDR_TRANSFER, 13'h000A};
  logic [7:0]  rst_t [7] = '{8'h0F, 8'h0F, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

  adc_channel_config_regs #(.NUM_CH(NUM_CH), .DW(DW)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csb(csb), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sample_tick(sample_tick),
    .adc_data(adc_data), .user_word1(user_word1), .user_word2(user_word2),
    .out_data(out_data), .test_active(test_active),
    .power_down(power_down), .standby(standby), .chip_reset(chip_reset),
    .preamp_bypass(preamp_bypass), .dcs_enable(dcs_enable),
    .frame_clock_output_sel(frame_sel), .data_clock_output_sel(data_sel));
  serial_host_model i_host (.clk_sys(clk_sys), .sclk(sclk), .csb(csb),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always @(posedge clk_sys) begin
    lfsr_q <= lfsr_next(lfsr_q);
    prev_adc <= adc_data;
    for (int c = 0; c < NUM_CH; c++) begin
      adc_data[c] <= lfsr_q[DW-1:0] + DW'(c * 291);
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Read results are matched against the oldest expectation
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("read unasked", 1, 0);
      else check("read data", rd_data, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [12:0] adr, input logic [7:0] d);
    logic [7:0] unused;
    i_host.xfer(1'b0, adr, d, unused);
  endtask

  task automatic rd(input logic [12:0] adr, input logic [7:0] e);
    logic [7:0] v;
    exp_q.push_back(e);
    i_host.xfer(1'b1, adr, 8'h00, v);
    @(posedge clk_sys);
  endtask

  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic tick();
    @(posedge clk_sys) sample_tick <= 1'b1;
    @(posedge clk_sys) sample_tick <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    user_word1 <= lfsr_q[DW-1:0] | 12'h001;
    user_word2 <= ~(lfsr_q[DW-1:0] | 12'h001);
    settle();
    check("dcs", dcs_enable, 1'b1);
    check("clk sel", {frame_sel, data_sel}, 2'b00);
    for (int i = 0; i < 7; i++) begin
      rd(addr_t[i], rst_t[i]);
    end
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODES, {4'hF, m[2], 1'b0, m[1:0]});
      settle();
      check("pwr", {chip_reset, standby, power_down},
            (32'h1 << m[1:0]) >> 1);
      check("bypass", preamp_bypass, m[2]);
      rd(ADDR_MODES, {4'h0, m[2], 1'b0, m[1:0]});
    end
    wr(ADDR_CLOCK, 8'hFE);
    settle();
    check("dcs off", dcs_enable, 1'b0);
    rd(ADDR_CLOCK, 8'h00);
    wr(ADDR_CLOCK, 8'h01);
    wr(ADDR_LOWER_SEL, 8'hF1);
    wr(ADDR_UPPER_SEL, 8'h00);
    settle();
    check("held sel", {frame_sel, data_sel}, 2'b00);
    rd(ADDR_LOWER_SEL, 8'h31);
    wr(ADDR_TRANSFER, 8'h01);
    settle();
    check("moved sel", {frame_sel, data_sel}, 2'b11);
    rd(ADDR_TRANSFER, 8'h00);
    wr(ADDR_TEST, 8'h02);
    settle();
    check("active", test_active, 8'h01);
    check("ch0", out_data[0], 12'hFFF);
    check("ch1", out_data[1], prev_adc[1]);
    rd(ADDR_TEST, 8'h02);
    for (int p = 1; p < 13; p++) begin
      wr(ADDR_TEST, 8'(p));
      if (p == 5 || p == 6) prs_all = 1'b1;
      settle();
      check("pattern", test_active, {{7{prs_all}}, 1'b1});
    end
    wr(ADDR_UPPER_SEL, 8'h0F);
    wr(ADDR_LOWER_SEL, 8'h0F);
    wr(ADDR_TRANSFER, 8'h01);
    wr(ADDR_TEST, 8'h00);
    settle();
    check("off", test_active, 8'h00);
    check("clk sel off", {frame_sel, data_sel}, 2'b00);
    for (int s = 2; s < 4; s++) begin
      wr(ADDR_TEST, {s[1:0], 6'h08});
      repeat (3) tick();
      settle();
      check("user end", out_data[0], 12'h000);
    end
    wr(ADDR_TEST, 8'h48);
    tick();
    settle();
    a = out_data[0];
    tick();
    settle();
    b = out_data[0];
    check("alt", a ^ b, user_word1 ^ user_word2);
    check("alt word", (a === user_word1) || (a === user_word2), 1'b1);
    wr(ADDR_TEST, 8'h38);
    rd(ADDR_TEST, 8'h38);
    wr(ADDR_TEST, 8'h16);
    tick();
    settle();
    check("short seed", out_data[3], {3'h0, PRS_SHORT_SEED});
    wr(ADDR_TEST, 8'h25);
    tick();
    settle();
    check("long seed", out_data[5], PRS_LONG_SEED[DW-1:0]);
    check("queue", exp_q.size(), 0);
    finish_test();
  end
endmodule

bind adc_channel_config_regs adc_cfg_monitor #(.NUM_CH(NUM_CH), .DW(DW))
  i_mon (.clk_sys(clk_sys), .rst(rst), .csb(csb), .adc_data(adc_data),
  .out_data(out_data), .test_active(test_active), .power_down(power_down),
  .standby(standby), .chip_reset(chip_reset),
  .preamp_bypass(preamp_bypass), .dcs_enable(dcs_enable),
  .frame_clock_output_sel(frame_clock_output_sel),
  .data_clock_output_sel(data_clock_output_sel));
